/* rtl/bit_unit_pkg.sv */
// Constants, register map and state types of the bit shift, rotate and test unit.
// Assumes a 32-bit AXI4-Lite register bus and a single core clock domain.
`default_nettype none
package bit_unit_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAGS_W = 5;
  localparam int STAT_W = 4;

  // Register byte offsets.
  localparam logic [7:0] OFS_DEST   = 8'h00;
  localparam logic [7:0] OFS_SRC    = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields.
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_OP_W    = 4;
  localparam int CTRL_W32_BIT = 4;
  localparam int CTRL_CNT_LSB = 8;
  localparam int CNT_W        = 5;

  // Bits of the status_flag_register.
  localparam int FLAG_CARRY    = 0;
  localparam int FLAG_PARITY   = 1;
  localparam int FLAG_ZERO     = 2;
  localparam int FLAG_SIGN     = 3;
  localparam int FLAG_OVERFLOW = 4;

  // Bits of the status register.
  localparam int STAT_BUSY       = 0;
  localparam int STAT_SCAN_EMPTY = 1;
  localparam int STAT_BAD_OP     = 2;
  localparam int STAT_DEST_WR    = 3;

  // Operation codes of the control register.
  localparam logic [3:0] OPC_FUNNEL_LEFT  = 4'h0;
  localparam logic [3:0] OPC_FUNNEL_RIGHT = 4'h1;
  localparam logic [3:0] OPC_ROT_LEFT     = 4'h2;
  localparam logic [3:0] OPC_ROT_RIGHT    = 4'h3;
  localparam logic [3:0] OPC_ROT_C_LEFT   = 4'h4;
  localparam logic [3:0] OPC_ROT_C_RIGHT  = 4'h5;
  localparam logic [3:0] OPC_BIT_TEST     = 4'h6;
  localparam logic [3:0] OPC_BIT_SET      = 4'h7;
  localparam logic [3:0] OPC_BIT_CLEAR    = 4'h8;
  localparam logic [3:0] OPC_BIT_INVERT   = 4'h9;
  localparam logic [3:0] OPC_SCAN_FWD     = 4'hA;
  localparam logic [3:0] OPC_SCAN_REV     = 4'hB;
  localparam logic [3:0] OPC_FLAG_BYTE    = 4'hC;
  localparam logic [3:0] OPC_TEST_AND     = 4'hD;

  localparam logic [31:0] MASK_W16 = 32'h0000FFFF;
  localparam logic [31:0] MASK_W32 = 32'hFFFFFFFF;
  localparam logic [4:0]  MSB_W16  = 5'h0F;
  localparam logic [4:0]  MSB_W32  = 5'h1F;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [31:0] RST_WORD  = 32'h00000000;
  localparam logic [4:0]  RST_FLAGS = 5'h00;

  typedef enum logic {EXEC_IDLE, EXEC_RUN} exec_st_t;

  typedef struct packed {
    logic [31:0] dest;
    logic [31:0] result;
    logic [4:0]  flags;
    logic        scan_empty;
    logic        bad_op;
    logic        wr_dest;
  } exec_res_t;

  typedef struct packed {
    logic [31:0]       dest;
    logic [31:0]       src;
    logic [31:0]       ctrl;
    logic [4:0]        flags;
    logic [31:0]       result;
    logic [STAT_W-1:0] status;
    exec_st_t          exec_st;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

endpackage

`default_nettype wire

/* rtl/bit_unit.sv */
// Bit shift, rotate, bit test, bit scan, flag-to-byte and AND-test datapath,
// reached as an AXI4-Lite slave. Software loads destination, source and flags,
// then a write to the control register runs one operation in the next cycle.
// Assumes one clock, an asynchronous active-low reset and a well-behaved master.
//
// Notes on behaviour
// - Left funnel fills low bits from source top.
// - Funnel operands are both 16 or 32 bits.
// - Funnel count ranges 0 through 31.
// - Funnel writes destination only, source untouched.
// - Funnel carry is last bit out of destination.
// - Rotates take 0 to 31, lose no bit.
// - Left rotates upward, right rotates downward.
// - Carry-left rotate chains carry above the top.
// - Carry-right rotate chains carry, moving downward.
// - Every rotate leaves last bit out in carry.
// - Bit test copies selected bit into carry first.
// - Test keeps, set forces 1, clear 0, invert.
// - Forward scan reports lowest set bit index.
// - Reverse scan reports highest set bit index.
// - Flag byte is 1 when condition true.
// - Overflow condition copies overflow flag into byte.
// - AND test updates sign, zero and parity.
// - AND test writes back neither operand.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module bit_unit (
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic [bit_unit_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                           s_axi_awvalid_i,
  output logic                                s_axi_awready_o,
  input  wire logic [bit_unit_pkg::DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]                     s_axi_wstrb_i,
  input  wire logic                           s_axi_wvalid_i,
  output logic                                s_axi_wready_o,
  output logic [1:0]                          s_axi_bresp_o,
  output logic                                s_axi_bvalid_o,
  input  wire logic                           s_axi_bready_i,
  input  wire logic [bit_unit_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                           s_axi_arvalid_i,
  output logic                                s_axi_arready_o,
  output logic [bit_unit_pkg::DATA_W-1:0]     s_axi_rdata_o,
  output logic [1:0]                          s_axi_rresp_o,
  output logic                                s_axi_rvalid_o,
  input  wire logic                           s_axi_rready_i
);
  import bit_unit_pkg::*;

  state_t q;
  state_t next_q;
  exec_res_t ex;

  function automatic logic [31:0] width_mask(input logic w32);
    width_mask = w32 ? MASK_W32 : MASK_W16;
  endfunction

  // Replaces only the bits that belong to the operand width.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_strb = r;
  endfunction

  // Condition codes follow the usual sixteen-entry order, pairs as true and negated.
  function automatic logic cond_eval(input logic [3:0] cc, input logic [4:0] f);
    logic c;
    c = 1'b0;
    case (cc[3:1])
      3'h0: c = f[FLAG_OVERFLOW];
      3'h1: c = f[FLAG_CARRY];
      3'h2: c = f[FLAG_ZERO];
      3'h3: c = f[FLAG_CARRY] | f[FLAG_ZERO];
      3'h4: c = f[FLAG_SIGN];
      3'h5: c = f[FLAG_PARITY];
      3'h6: c = f[FLAG_SIGN] ^ f[FLAG_OVERFLOW];
      3'h7: c = (f[FLAG_SIGN] ^ f[FLAG_OVERFLOW]) | f[FLAG_ZERO];
      default: c = 1'b0;
    endcase
    cond_eval = c ^ cc[0];
  endfunction

  function automatic exec_res_t run_op(input logic [3:0]  op,
                                       input logic        w32,
                                       input logic [4:0]  cnt,
                                       input logic [31:0] d,
                                       input logic [31:0] s,
                                       input logic [4:0]  f);
    exec_res_t   r;
    logic [63:0] v;
    logic [63:0] sh;
    logic [63:0] sh1;
    logic [31:0] x;
    logic [31:0] m;
    logic [4:0]  off;
    logic        cy;
    logic        outb;
    logic        inb;
    logic        hit;
    logic        left;
    logic        thru;
    r.dest       = d;
    r.result     = RST_WORD;
    r.flags      = f;
    r.scan_empty = 1'b0;
    r.bad_op     = 1'b0;
    r.wr_dest    = 1'b0;
    // Defaults keep every local defined on paths that do not use it.
    v    = 64'h0000000000000000;
    sh   = 64'h0000000000000000;
    sh1  = 64'h0000000000000000;
    outb = 1'b0;
    inb  = 1'b0;

    m    = width_mask(w32);
    x    = d & m;
    cy   = f[FLAG_CARRY];
    hit  = 1'b0;
    left = (op == OPC_ROT_LEFT) || (op == OPC_ROT_C_LEFT);
    thru = (op == OPC_ROT_C_LEFT) || (op == OPC_ROT_C_RIGHT);
    off  = w32 ? cnt : {1'b0, cnt[3:0]};

    case (op)
      OPC_FUNNEL_LEFT: begin
        // The 16-bit form packs both operands at the top of the 64-bit window.
        v   = w32 ? {d, s} : {d[15:0], s[15:0], 32'h00000000};
        sh  = v << cnt;
        sh1 = v << (cnt - 5'h01);
        r.result = w32 ? sh[63:32] : {16'h0000, sh[63:48]};
        if (cnt != 5'h00) begin
          r.dest             = merge(d, r.result, m);
          r.wr_dest          = 1'b1;
          r.flags[FLAG_CARRY] = sh1[63];
        end else begin
          r.result = x;
        end
      end

      OPC_FUNNEL_RIGHT: begin
        v   = w32 ? {s, d} : {32'h00000000, s[15:0], d[15:0]};
        sh  = v >> cnt;
        sh1 = v >> (cnt - 5'h01);
        r.result = sh[31:0] & m;
        if (cnt != 5'h00) begin
          r.dest             = merge(d, r.result, m);
          r.wr_dest          = 1'b1;
          r.flags[FLAG_CARRY] = sh1[0];
        end else begin
          r.result = x;
        end
      end

      OPC_ROT_LEFT, OPC_ROT_RIGHT, OPC_ROT_C_LEFT, OPC_ROT_C_RIGHT: begin
        // One step per bit keeps the carry chain exact for either width.
        for (int i = 0; i < 32; i++) begin
          if (i < int'(cnt)) begin
            if (left) begin
              outb = w32 ? x[31] : x[15];
              inb  = thru ? cy : outb;
              x    = ((x << 1) | {31'h00000000, inb}) & m;
            end else begin
              outb = x[0];
              inb  = thru ? cy : outb;
              x    = (x >> 1) | ({31'h00000000, inb} << (w32 ? MSB_W32 : MSB_W16));
            end
            cy = outb;
          end
        end
        r.result            = x;
        r.dest              = merge(d, x, m);
        r.wr_dest           = 1'b1;
        r.flags[FLAG_CARRY] = cy;
      end

      OPC_BIT_TEST, OPC_BIT_SET, OPC_BIT_CLEAR, OPC_BIT_INVERT: begin
        r.flags[FLAG_CARRY] = d[off];
        x = d;
        case (op)
          OPC_BIT_SET:    x[off] = 1'b1;
          OPC_BIT_CLEAR:  x[off] = 1'b0;
          OPC_BIT_INVERT: x[off] = ~d[off];
          default:        x[off] = d[off];
        endcase
        r.result  = x & m;
        r.dest    = merge(d, x, m);
        r.wr_dest = (op != OPC_BIT_TEST);
      end

      OPC_SCAN_FWD: begin
        x = s & m;
        for (int i = 0; i < 32; i++) begin
          if (!hit && x[i]) begin
            hit      = 1'b1;
            r.result = 32'(i);
          end
        end
        r.flags[FLAG_ZERO] = ~hit;
        r.scan_empty       = ~hit;
        r.wr_dest          = hit;
        r.dest             = hit ? merge(d, r.result, m) : d;
      end

      OPC_SCAN_REV: begin
        x = s & m;
        for (int i = 31; i >= 0; i--) begin
          if (!hit && x[i]) begin
            hit      = 1'b1;
            r.result = 32'(i);
          end
        end
        r.flags[FLAG_ZERO] = ~hit;
        r.scan_empty       = ~hit;
        r.wr_dest          = hit;
        r.dest             = hit ? merge(d, r.result, m) : d;
      end

      OPC_FLAG_BYTE: begin
        r.result  = {31'h00000000, cond_eval(cnt[3:0], f)};
        r.dest    = {d[31:8], r.result[7:0]};
        r.wr_dest = 1'b1;
      end

      OPC_TEST_AND: begin
        x = d & s & m;
        r.result            = x;
        r.flags[FLAG_SIGN]   = w32 ? x[31] : x[15];
        r.flags[FLAG_ZERO]   = (x == 32'h00000000);
        r.flags[FLAG_PARITY] = ~^x[7:0];
        r.wr_dest            = 1'b0;
      end

      default: begin
        r.bad_op = 1'b1;
      end
    endcase
    run_op = r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_DEST) || (a == OFS_SRC) || (a == OFS_CTRL) ||
                (a == OFS_FLAGS) || (a == OFS_RESULT) || (a == OFS_STATUS);
  endfunction

  assign ex = run_op(q.ctrl[CTRL_OP_LSB +: CTRL_OP_W], q.ctrl[CTRL_W32_BIT],
                     q.ctrl[CTRL_CNT_LSB +: CNT_W], q.dest, q.src, q.flags);

  // A new address or data beat is held off until the previous one is used.
  assign s_axi_awready_o = ~q.aw_got;
  assign s_axi_wready_o  = ~q.w_got;
  assign s_axi_arready_o = ~q.rvalid;
  assign s_axi_bvalid_o  = q.bvalid;
  assign s_axi_bresp_o   = q.bresp;
  assign s_axi_rvalid_o  = q.rvalid;
  assign s_axi_rdata_o   = q.rdata;
  assign s_axi_rresp_o   = q.rresp;

  always_comb begin
    next_q = q;
    if (q.exec_st == EXEC_RUN) begin
      // The source register is never a target here.
      if (ex.wr_dest) begin
        next_q.dest = ex.dest;
      end
      next_q.flags                   = ex.flags;
      next_q.result                  = ex.result;
      next_q.status[STAT_SCAN_EMPTY] = ex.scan_empty;
      next_q.status[STAT_BAD_OP]     = ex.bad_op;
      next_q.status[STAT_DEST_WR]    = ex.wr_dest;
      next_q.exec_st                 = EXEC_IDLE;
    end

    if (s_axi_awvalid_i && ~q.aw_got) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = s_axi_awaddr_i;
    end

    if (s_axi_wvalid_i && ~q.w_got) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata_i;
      next_q.wstrb = s_axi_wstrb_i;
    end

    // Writes wait out a running operation so software never races the datapath.
    if (q.aw_got && q.w_got && ~q.bvalid && q.exec_st == EXEC_IDLE) begin
      next_q.aw_got = 1'b0;
      next_q.w_got  = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = is_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (q.awaddr)
        OFS_DEST:  next_q.dest = apply_strb(q.dest, q.wdata, q.wstrb);
        OFS_SRC:   next_q.src  = apply_strb(q.src, q.wdata, q.wstrb);
        OFS_FLAGS: begin
          next_q.flags = FLAGS_W'(apply_strb({27'h0000000, q.flags}, q.wdata, q.wstrb));
        end
        OFS_CTRL: begin
          next_q.ctrl    = apply_strb(q.ctrl, q.wdata, q.wstrb);
          next_q.exec_st = EXEC_RUN;
        end
        default: next_q.dest = q.dest;
      endcase
    end

    if (q.bvalid && s_axi_bready_i) begin
      next_q.bvalid = 1'b0;
    end

    if (q.rvalid && s_axi_rready_i) begin
      next_q.rvalid = 1'b0;
    end

    if (s_axi_arvalid_i && ~q.rvalid) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr_i)
        OFS_DEST:   next_q.rdata = q.dest;
        OFS_SRC:    next_q.rdata = q.src;
        OFS_CTRL:   next_q.rdata = q.ctrl;
        OFS_FLAGS:  next_q.rdata = {27'h0000000, q.flags};
        OFS_RESULT: next_q.rdata = q.result;
        OFS_STATUS: begin
          next_q.rdata = {28'h0000000, q.status};
        end
        default:    next_q.rdata = RST_WORD;
      endcase
    end

    // Busy follows the run state, so a status read during the run cycle sees it.
    next_q.status[STAT_BUSY] = (next_q.exec_st == EXEC_RUN);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q.dest    <= RST_WORD;
      q.src     <= RST_WORD;
      q.ctrl    <= RST_WORD;
      q.flags   <= RST_FLAGS;
      q.result  <= RST_WORD;
      q.status  <= 4'h0;
      q.exec_st <= EXEC_IDLE;
      q.aw_got  <= 1'b0;
      q.w_got   <= 1'b0;
      q.awaddr  <= 8'h00;
      q.wdata   <= RST_WORD;
      q.wstrb   <= 4'h0;
      q.bvalid  <= 1'b0;
      q.bresp   <= RESP_OKAY;
      q.rvalid  <= 1'b0;
      q.rdata   <= RST_WORD;
      q.rresp   <= RESP_OKAY;
    end else begin
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

/* bench/bit_unit_assertions.sv */
// Bus-level checker of the bit unit, bound to its top module.
// Assumes the ports of bit_unit, one clock and an active-low reset.
`timescale 1ns/1ns
`default_nettype none
module bit_unit_checker
  import bit_unit_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  logic [7:0]  rd_adr;
  logic [7:0]  wr_adr;
  logic [31:0] wr_dat;
  logic [31:0] src_sh;
  logic [31:0] dest_sh;
  logic        dest_ok;
  logic        b_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Shadows follow committed writes; dest_ok drops once an op may rewrite the destination.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_adr  <= 8'h00;
      wr_adr  <= 8'h00;
      wr_dat  <= 32'h0;
      src_sh  <= 32'h0;
      dest_sh <= 32'h0;
      dest_ok <= 1'b1;
      b_q     <= 1'b0;
    end else begin
      b_q <= s_axi_bvalid_o;
      if (s_axi_arvalid_i && s_axi_arready_o) rd_adr <= s_axi_araddr_i;
      if (s_axi_awvalid_i && s_axi_awready_o) wr_adr <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) wr_dat <= s_axi_wdata_i;
      if (s_axi_bvalid_o && !b_q && s_axi_bresp_o == RESP_OKAY) begin
        if (wr_adr == OFS_SRC) src_sh <= wr_dat;
        if (wr_adr == OFS_DEST) begin
          dest_sh <= wr_dat;
          dest_ok <= 1'b1;
        end
        if (wr_adr == OFS_CTRL && !(wr_dat[3:0] inside {OPC_BIT_TEST, OPC_TEST_AND}))
          dest_ok <= 1'b0;
      end
    end
  end
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read data dropped early");
  r_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  ar_gate_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while data stands");
  b_lat_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:4] s_axi_bvalid_o) else $error("write answer late");
  src_keep_a: assert property ($rose(s_axi_rvalid_o) && rd_adr == OFS_SRC
    |-> s_axi_rdata_o == src_sh) else $error("source word altered");
  dest_keep_a: assert property ($rose(s_axi_rvalid_o) && rd_adr == OFS_DEST
    && dest_ok |-> s_axi_rdata_o == dest_sh) else $error("destination altered");
  unmap_rd_a: assert property ($rose(s_axi_rvalid_o) && rd_adr > OFS_STATUS
    |-> s_axi_rdata_o == 32'h0 && s_axi_rresp_o == RESP_SLVERR) else $error("unmapped read");
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
  c_dest: cover property ($rose(s_axi_rvalid_o) && rd_adr == OFS_DEST && dest_ok);
  c_both: cover property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i);
endmodule
bind bit_unit bit_unit_checker u_chk (.*);
`default_nettype wire

/* bench/op_issuer.sv */
// Register-bus master standing in for the decoder and register file.
// Assumes it is called from one process at a time; releases buses to inverted values.
`timescale 1ns/1ns
`default_nettype none
module op_issuer (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
    {bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    {awaddr_o, wdata_o, wstrb_o} <= {a, d, 4'hF};
    {awvalid_o, wvalid_o, bready_o} <= 3'h7;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
      if (bvalid_i && bready_o) begin
        r = bresp_i;
        bready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    araddr_o <= a;
    {arvalid_o, rready_o} <= 2'h3;
    while (!done) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
      end
      if (rvalid_i && rready_o) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_bit_shift_rotate_test_unit.sv */
// Self-checking bench of the bit unit: loads operands, runs one op, reads back.
// Assumes the checker is bound to bit_unit and op_issuer drives the bus.
`timescale 1ns/1ns
`default_nettype none
module tb_bit_shift_rotate_test_unit;
  import bit_unit_pkg::*;
  logic clk_i, arst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, got;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
  int          miscompares, cmp_count;
  bit_unit u_dut (.*);
  op_issuer u_host (
    .clk_i(clk_i), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  function automatic logic [31:0] c(input logic [3:0] op, input logic [4:0] cnt);
    return {19'h0, cnt, 3'h0, 1'h1, op};
  endfunction
  task automatic run(input logic [31:0] ctl, d, s, input logic [4:0] f,
                     input logic [31:0] ed, input logic [4:0] ef);
    u_host.wr(OFS_DEST, d, rsp);
    u_host.wr(OFS_SRC, s, rsp);
    u_host.wr(OFS_FLAGS, {27'h0, f}, rsp);
    u_host.wr(OFS_CTRL, ctl, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "write response");
    u_host.rd(OFS_DEST, got, rsp);
    chk(got, ed, "dest");
    u_host.rd(OFS_FLAGS, got, rsp);
    chk(got, {27'h0, ef}, "flags");
    u_host.rd(OFS_SRC, got, rsp);
    chk(got, s, "source");
  endtask
  task automatic t_bus();
    for (int i = 0; i < 6; i++) begin
      u_host.rd(8'(4 * i), got, rsp);
      chk(got, 32'h0, "reset value");
      chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "read response");
    end
    u_host.rd(8'h20, got, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    u_host.wr(8'h20, 32'h1, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    u_host.wr(OFS_RESULT, 32'hFFFFFFFF, rsp);
    u_host.rd(OFS_RESULT, got, rsp);
    chk(got, 32'h0, "read-only word");
  endtask
  task automatic t_funnel();
    run(c(OPC_FUNNEL_LEFT, 5'h04), 32'h12345678, 32'hABCDEF01,
        5'h00, 32'h2345678A, 5'h01);
    run(c(OPC_FUNNEL_RIGHT, 5'h04), 32'h12345677, 32'hABCDEF01,
        5'h1F, 32'h11234567, 5'h1E);
    run(c(OPC_FUNNEL_LEFT, 5'h1F), 32'h2, 32'h80000000, 5'h00, 32'h40000000, 5'h01);
    run(c(OPC_FUNNEL_LEFT, 5'h08) & ~32'h10, 32'hAAAA1234, 32'hBEEF, 5'h01,
        32'hAAAA34BE, 5'h00);
  endtask
  task automatic t_rotate();
    run(c(OPC_ROT_LEFT, 5'h04), 32'hF0000000, 32'h0, 5'h00, 32'hF, 5'h01);
    run(c(OPC_ROT_RIGHT, 5'h04), 32'h7, 32'h0, 5'h1F, 32'h70000000, 5'h1E);
    run(c(OPC_ROT_RIGHT, 5'h1F), 32'h1, 32'h0, 5'h01, 32'h2, 5'h00);
    run(c(OPC_ROT_LEFT, 5'h00), 32'h12345678, 32'h0, 5'h01, 32'h12345678, 5'h01);
    run(c(OPC_ROT_C_LEFT, 5'h01), 32'h0, 32'h0, 5'h01, 32'h1, 5'h00);
    run(c(OPC_ROT_C_LEFT, 5'h04), 32'h90000000, 32'h0, 5'h01, 32'hC, 5'h01);
    run(c(OPC_ROT_C_RIGHT, 5'h01), 32'h1, 32'h0, 5'h00, 32'h0, 5'h01);
  endtask
  task automatic t_bits();
    run(c(OPC_BIT_TEST, 5'h04), 32'h10, 32'h0, 5'h00, 32'h10, 5'h01);
    run(c(OPC_BIT_SET, 5'h05), 32'h10, 32'h0, 5'h01, 32'h30, 5'h00);
    run(c(OPC_BIT_CLEAR, 5'h04), 32'h10, 32'h0, 5'h00, 32'h0, 5'h01);
    run(c(OPC_BIT_INVERT, 5'h1F), 32'h10, 32'h0, 5'h01, 32'h80000010, 5'h00);
  endtask
  task automatic t_scan();
    run(c(OPC_SCAN_FWD, 5'h00), 32'hFFFFFFFF, 32'h80000001, 5'h04, 32'h0, 5'h00);
    run(c(OPC_SCAN_REV, 5'h00), 32'hFFFFFFFF, 32'h80000001, 5'h04, 32'h1F, 5'h00);
    run(c(OPC_SCAN_FWD, 5'h00), 32'h12345678, 32'h0, 5'h00, 32'h12345678, 5'h04);
    u_host.rd(OFS_STATUS, got, rsp);
    chk({31'h0, got[STAT_SCAN_EMPTY]}, 32'h1, "empty scan status");
  endtask
  task automatic t_flag_byte();
    logic [4:0] f;
    logic       e;
    for (int k = 0; k < 32; k++) begin
      f = k[4] ? 5'h15 : 5'h0A;
      case (k[3:1])
        3'h0: e = f[FLAG_OVERFLOW];
        3'h1: e = f[FLAG_CARRY];
        3'h2: e = f[FLAG_ZERO];
        3'h3: e = f[FLAG_CARRY] | f[FLAG_ZERO];
        3'h4: e = f[FLAG_SIGN];
        3'h5: e = f[FLAG_PARITY];
        3'h6: e = f[FLAG_SIGN] ^ f[FLAG_OVERFLOW];
        default: e = (f[FLAG_SIGN] ^ f[FLAG_OVERFLOW]) | f[FLAG_ZERO];
      endcase
      run(c(OPC_FLAG_BYTE, {1'h0, k[3:0]}), 32'hAAAAAA55, 32'h0, f,
          {24'hAAAAAA, 7'h00, e ^ k[0]}, f);
    end
  endtask
  task automatic t_test();
    run(c(OPC_TEST_AND, 5'h00), 32'hF0F0F0F0, 32'h8F0F0F03, 5'h11,
        32'hF0F0F0F0, 5'h1B);
    u_host.rd(OFS_RESULT, got, rsp);
    chk(got, 32'h80000000, "and value");
    run(c(OPC_TEST_AND, 5'h00), 32'hFF00, 32'hFF, 5'h08, 32'hFF00, 5'h06);
    run(c(OPC_TEST_AND, 5'h00), 32'h7, 32'hFFFFFFFF, 5'h0E, 32'h7, 5'h00);
    run(c(4'hE, 5'h03), 32'h5, 32'h9, 5'h1F, 32'h5, 5'h1F);
    u_host.rd(OFS_STATUS, got, rsp);
    chk(got, 32'h1 << STAT_BAD_OP, "bad opcode status");
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    miscompares = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_bus();
    t_funnel();
    t_rotate();
    t_bits();
    t_scan();
    t_flag_byte();
    t_test();
    report_and_stop();
  end
  // About 1,400 cycles of traffic are expected; the margin covers slow answers.
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
